// File: rtl/rsi_regs.vh
`ifndef RSI_REGS_VH
`define RSI_REGS_VH

// Register byte offsets (word aligned)
`define RSI_OFF_TOP_OF_STACK_UPPER        8'h00
`define RSI_OFF_TOP_OF_STACK_HIGH        8'h04
`define RSI_OFF_TOP_OF_STACK_LOW        8'h08
`define RSI_OFF_RETURN_STACK_POINTER      8'h0c
`define RSI_OFF_PCL         8'h10
`define RSI_OFF_INTCTL      8'h14
`define RSI_OFF_OSCCTL      8'h18
`define RSI_OFF_VDCTL       8'h1c
`define RSI_OFF_T1CTL       8'h20
`define RSI_OFF_T2PER       8'h24
`define RSI_OFF_CMPCTL      8'h28
`define RSI_OFF_TXCTL       8'h2c
`define RSI_OFF_NVUNLOCK    8'h30
`define RSI_OFF_SYSCTL      8'h34
`define RSI_OFF_IRQFLG      8'h38
`define RSI_OFF_CAUSE       8'h3c

// Implemented-bit masks
`define RSI_MASK_TOP_OF_STACK_UPPER       8'h1f
`define RSI_MASK_RETURN_STACK_POINTER     8'hdf
`define RSI_MASK_PCL        8'hfe
`define RSI_MASK_VDCTL      8'hbf
`define RSI_MASK_SYSCTL     8'h01

// Field positions
`define RSI_STK_FULL        7
`define RSI_STK_UNF         6
`define RSI_T1_CLR_BIT      6
`define RSI_OSC_QRST_BIT    3
`define RSI_OSC_QWAKE_BIT   1
`define RSI_INT_KEEP_BIT    0

// Reset values
`define RSI_RST_ZERO        8'h00
`define RSI_RST_OSCCTL      8'h40
`define RSI_RST_VDCTL       8'h05
`define RSI_RST_T2PER       8'hff
`define RSI_RST_CMPCTL      8'h07
`define RSI_RST_TXCTL       8'h02

// Program addresses
`define RSI_VEC_HIGH        21'h000008
`define RSI_VEC_LOW         21'h000018
`define RSI_PC_STEP         21'h000002
`define RSI_RESET_PC        21'h000000

// Brown-out software mode
`define RSI_BO_SOFT         2'b01

// Event classes
`define RSI_CLS_NONE        2'd0
`define RSI_CLS_POR         2'd1
`define RSI_CLS_MASTER_CLEAR_PIN        2'd2
`define RSI_CLS_WAKE        2'd3

`endif

// File: rtl/rsi_top.v
`timescale 1ns/100ps
`include "rsi_regs.vh"

module rsi_top #(
    parameter ADDR_W = 8,
    parameter PC_W   = 21
) (
    input  wire              clk_in,
    input  wire              rst_in,
    input  wire [ADDR_W-1:0] avs_address_in,
    input  wire              avs_read_in,
    input  wire              avs_write_in,
    input  wire [31:0]       avs_writedata_in,
    input  wire [3:0]        avs_byteenable_in,
    output reg  [31:0]       avs_readdata_out,
    output reg               avs_waitrequest_out,
    input  wire              por_event_in,
    input  wire              master_clear_pin_class_event_in,
    input  wire              wake_watchdog_in,
    input  wire              wake_irq_in,
    input  wire              wake_irq_high_in,
    input  wire [7:0]        irq_source_in,
    input  wire              global_high_irq_enable_in,
    input  wire              global_low_irq_enable_in,
    input  wire [PC_W-1:0]   pc_in,
    input  wire [1:0]        brownout_config_field_in,
    input  wire              osc_reset_cond_in,
    input  wire              osc_wake_cond_in,
    output reg               pc_load_out,
    output reg  [PC_W-1:0]   pc_value_out,
    output reg  [1:0]        init_class_out,
    output reg               soft_brownout_enable_out
);

    reg [7:0] top_of_stack_upper;
    reg [7:0] top_of_stack_high;
    reg [7:0] top_of_stack_low;
    reg [7:0] return_stack_pointer;
    reg [7:0] program_counter_low;
    reg [7:0] interrupt_control_primary;
    reg [7:0] oscillator_control;
    reg [7:0] voltage_detect_control;
    reg [7:0] timer_one_control;
    reg [7:0] timer_two_period;
    reg [7:0] comparator_control;
    reg [7:0] serial_tx_status_control;
    reg [7:0] peripheral_irq_flags;
    reg       soft_brownout_enable;
    reg [1:0] last_class;

    reg [7:0]      rd_byte;
    reg [PC_W-1:0] next_pc;

    wire           cls_por;
    wire           cls_master_clear_pin;
    wire           cls_wake;
    wire           irq_vector;
    wire           bus_wr;
    wire [7:0]     wr_byte;
    wire           soft_mode;
    wire [PC_W-1:0] pc_plus_two;

    // Severity order decides which set applies
    assign cls_por    = por_event_in;
    assign cls_master_clear_pin   = master_clear_pin_class_event_in & ~por_event_in;
    assign cls_wake   = (wake_watchdog_in | wake_irq_in) & ~por_event_in & ~master_clear_pin_class_event_in;
    assign irq_vector = cls_wake & wake_irq_in &
                        (global_high_irq_enable_in | global_low_irq_enable_in);
    assign soft_mode  = (brownout_config_field_in == `RSI_BO_SOFT);
    assign pc_plus_two = pc_in + `RSI_PC_STEP;

    // Write lands on the edge where the master sees waitrequest low
    assign bus_wr  = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
    assign wr_byte = avs_writedata_in[7:0];

    always @* begin
        if (irq_vector) begin
            next_pc = wake_irq_high_in ? `RSI_VEC_HIGH : `RSI_VEC_LOW;
        end else if (cls_wake) begin
            next_pc = pc_plus_two;
        end else begin
            next_pc = `RSI_RESET_PC;
        end
    end

    // Read mux; masks keep absent bits at zero
    always @* begin
        case (avs_address_in)
            `RSI_OFF_TOP_OF_STACK_UPPER:     rd_byte = top_of_stack_upper & `RSI_MASK_TOP_OF_STACK_UPPER;
            `RSI_OFF_TOP_OF_STACK_HIGH:     rd_byte = top_of_stack_high;
            `RSI_OFF_TOP_OF_STACK_LOW:     rd_byte = top_of_stack_low;
            `RSI_OFF_RETURN_STACK_POINTER:   rd_byte = return_stack_pointer & `RSI_MASK_RETURN_STACK_POINTER;
            `RSI_OFF_PCL:      rd_byte = program_counter_low & `RSI_MASK_PCL;
            `RSI_OFF_INTCTL:   rd_byte = interrupt_control_primary;
            `RSI_OFF_OSCCTL:   rd_byte = oscillator_control;
            `RSI_OFF_VDCTL:    rd_byte = voltage_detect_control & `RSI_MASK_VDCTL;
            `RSI_OFF_T1CTL:    rd_byte = timer_one_control;
            `RSI_OFF_T2PER:    rd_byte = timer_two_period;
            `RSI_OFF_CMPCTL:   rd_byte = comparator_control;
            `RSI_OFF_TXCTL:    rd_byte = serial_tx_status_control;
            `RSI_OFF_NVUNLOCK: rd_byte = `RSI_RST_ZERO;
            // Bit reads 0 outside software mode
            `RSI_OFF_SYSCTL:   rd_byte = {7'h00, soft_brownout_enable & soft_mode};
            `RSI_OFF_IRQFLG:   rd_byte = peripheral_irq_flags;
            `RSI_OFF_CAUSE:    rd_byte = {6'h00, last_class};
            default:           rd_byte = `RSI_RST_ZERO;
        endcase
    end

    // Bus handshake: one wait cycle, then one ready cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
        end else if ((avs_read_in | avs_write_in) & avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= {24'h000000, rd_byte};
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // Core-facing outputs
    always @(posedge clk_in) begin
        if (rst_in) begin
            pc_load_out              <= 1'b0;
            pc_value_out             <= `RSI_RESET_PC;
            init_class_out           <= `RSI_CLS_NONE;
            soft_brownout_enable_out <= 1'b0;
        end else begin
            pc_load_out              <= cls_por | cls_master_clear_pin | cls_wake;
            if (cls_por | cls_master_clear_pin | cls_wake) begin
                pc_value_out <= next_pc;
            end
            if (cls_por) begin
                init_class_out <= `RSI_CLS_POR;
            end else if (cls_master_clear_pin) begin
                init_class_out <= `RSI_CLS_MASTER_CLEAR_PIN;
            end else if (cls_wake) begin
                init_class_out <= `RSI_CLS_WAKE;
            end else begin
                init_class_out <= `RSI_CLS_NONE;
            end
            soft_brownout_enable_out <= soft_brownout_enable & soft_mode;
        end
    end

    // Register file: bus writes first, events override in the same cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            top_of_stack_upper        <= `RSI_RST_ZERO;
            top_of_stack_high         <= `RSI_RST_ZERO;
            top_of_stack_low          <= `RSI_RST_ZERO;
            return_stack_pointer      <= `RSI_RST_ZERO;
            program_counter_low       <= `RSI_RST_ZERO;
            interrupt_control_primary <= `RSI_RST_ZERO;
            oscillator_control        <= `RSI_RST_OSCCTL;
            voltage_detect_control    <= `RSI_RST_VDCTL;
            timer_one_control         <= `RSI_RST_ZERO;
            timer_two_period          <= `RSI_RST_T2PER;
            comparator_control        <= `RSI_RST_CMPCTL;
            serial_tx_status_control  <= `RSI_RST_TXCTL;
            peripheral_irq_flags      <= `RSI_RST_ZERO;
            soft_brownout_enable      <= 1'b0;
            last_class                <= `RSI_CLS_NONE;
        end else begin
            if (bus_wr) begin
                case (avs_address_in)
                    `RSI_OFF_TOP_OF_STACK_UPPER:   top_of_stack_upper <= wr_byte & `RSI_MASK_TOP_OF_STACK_UPPER;
                    `RSI_OFF_TOP_OF_STACK_HIGH:   top_of_stack_high <= wr_byte;
                    `RSI_OFF_TOP_OF_STACK_LOW:   top_of_stack_low <= wr_byte;
                    `RSI_OFF_RETURN_STACK_POINTER: return_stack_pointer <= wr_byte & `RSI_MASK_RETURN_STACK_POINTER;
                    `RSI_OFF_PCL:    program_counter_low <= wr_byte & `RSI_MASK_PCL;
                    `RSI_OFF_INTCTL: interrupt_control_primary <= wr_byte;
                    `RSI_OFF_OSCCTL: oscillator_control <= wr_byte;
                    `RSI_OFF_VDCTL:  voltage_detect_control <= wr_byte & `RSI_MASK_VDCTL;
                    `RSI_OFF_T1CTL:  timer_one_control <= wr_byte;
                    `RSI_OFF_T2PER:  timer_two_period <= wr_byte;
                    `RSI_OFF_CMPCTL: comparator_control <= wr_byte;
                    `RSI_OFF_TXCTL:  serial_tx_status_control <= wr_byte;
                    `RSI_OFF_SYSCTL: soft_brownout_enable <= wr_byte[0];
                    // Write one to clear; a new source bit wins below
                    `RSI_OFF_IRQFLG: peripheral_irq_flags <= peripheral_irq_flags & ~wr_byte;
                    default: ;
                endcase
            end

            if (cls_por | cls_master_clear_pin) begin
                top_of_stack_upper       <= `RSI_RST_ZERO;
                top_of_stack_high        <= `RSI_RST_ZERO;
                top_of_stack_low         <= `RSI_RST_ZERO;
                program_counter_low      <= `RSI_RST_ZERO;
                oscillator_control       <= `RSI_RST_OSCCTL |
                                            ({7'h00, osc_reset_cond_in} << `RSI_OSC_QRST_BIT);
                voltage_detect_control   <= `RSI_RST_VDCTL;
                comparator_control       <= `RSI_RST_CMPCTL;
                serial_tx_status_control <= `RSI_RST_TXCTL;
                timer_two_period         <= `RSI_RST_T2PER;
                peripheral_irq_flags     <= `RSI_RST_ZERO;
                // Bit 0 has no defined reset value: left as it was
                interrupt_control_primary <= interrupt_control_primary &
                                             (8'h01 << `RSI_INT_KEEP_BIT);
            end

            if (cls_por) begin
                last_class           <= `RSI_CLS_POR;
                return_stack_pointer <= `RSI_RST_ZERO;
                timer_one_control    <= `RSI_RST_ZERO;
                soft_brownout_enable <= soft_mode;
            end else if (cls_master_clear_pin) begin
                last_class           <= `RSI_CLS_MASTER_CLEAR_PIN;
                // Keep overflow and underflow flags, clear the pointer
                return_stack_pointer <= return_stack_pointer &
                                        ((8'h01 << `RSI_STK_FULL) | (8'h01 << `RSI_STK_UNF));
                timer_one_control    <= timer_one_control & ~(8'h01 << `RSI_T1_CLR_BIT);
                soft_brownout_enable <= soft_brownout_enable & soft_mode;
            end else if (cls_wake) begin
                last_class       <= `RSI_CLS_WAKE;
                timer_two_period <= `RSI_RST_T2PER;
                // Only bit 1 follows the wake condition
                oscillator_control[`RSI_OSC_QWAKE_BIT] <= osc_wake_cond_in;
                program_counter_low <= next_pc[7:0] & `RSI_MASK_PCL;
                soft_brownout_enable <= soft_brownout_enable & soft_mode;
                if (wake_irq_in) begin
                    // Set wins over a same-cycle clear
                    peripheral_irq_flags <= (bus_wr && avs_address_in == `RSI_OFF_IRQFLG ?
                                             peripheral_irq_flags & ~wr_byte :
                                             peripheral_irq_flags) | irq_source_in;
                end
                if (irq_vector) begin
                    top_of_stack_upper <= {3'b000, pc_in[20:16]};
                    top_of_stack_high  <= pc_in[15:8];
                    top_of_stack_low   <= pc_in[7:0];
                    if (return_stack_pointer[4:0] == 5'h1f) begin
                        // Pointer saturates; overflow flag records the lost push
                        return_stack_pointer[`RSI_STK_FULL] <= 1'b1;
                    end else begin
                        return_stack_pointer[4:0] <= return_stack_pointer[4:0] + 5'h01;
                    end
                end
            end
        end
    end

endmodule

// File: testbench/rsi_core_model.sv
`timescale 1ns/100ps
module rsi_core_model (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        pc_load_in,
    input  wire [20:0] pc_value_in,
    input  wire        set_en_in,
    input  wire [20:0] set_pc_in,
    output reg  [20:0] pc_out = 21'h000000
);
    // Core follows every load unless set_en_in forces set_pc_in, so the next wake sees the redirected PC
    always @(posedge clk_in) begin
        if (rst_in) begin
            pc_out <= 21'h000000;
        end else if (set_en_in) begin
            pc_out <= set_pc_in;
        end else if (pc_load_in) begin
            pc_out <= pc_value_in;
        end
    end
endmodule

// File: testbench/rsi_top_properties.sv
`timescale 1ns/100ps
module rsi_chk #(
    parameter PC_W = 21
) (
    input wire            clk_in,
    input wire            rst_in,
    input wire            por_event_in,
    input wire            master_clear_pin_class_event_in,
    input wire            wake_watchdog_in,
    input wire            wake_irq_in,
    input wire            wake_irq_high_in,
    input wire            global_high_irq_enable_in,
    input wire            global_low_irq_enable_in,
    input wire [PC_W-1:0] pc_in,
    input wire [1:0]      brownout_config_field_in,
    input wire            pc_load_out,
    input wire [PC_W-1:0] pc_value_out,
    input wire [1:0]      init_class_out,
    input wire            soft_brownout_enable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire hi  = por_event_in | master_clear_pin_class_event_in;
    wire wk  = ~hi & (wake_irq_in | wake_watchdog_in);
    wire vec = wk & wake_irq_in & (global_high_irq_enable_in | global_low_irq_enable_in);
    wire bo1 = brownout_config_field_in == 2'b01;
    AST_POR: assert property (por_event_in |=> pc_load_out && init_class_out == 2'd1
        && pc_value_out == '0) else $error("power-on load wrong");
    AST_MASTER_CLEAR_PIN: assert property (master_clear_pin_class_event_in && !por_event_in
        |=> init_class_out == 2'd2) else $error("master-clear class wrong");
    AST_WAKE: assert property (wk |=> pc_load_out && init_class_out == 2'd3)
        else $error("wake class wrong");
    AST_VEC_HIGH: assert property (vec && wake_irq_high_in
        |=> pc_value_out == 21'h000008) else $error("high vector wrong");
    AST_VEC_LOW: assert property (vec && !wake_irq_high_in
        |=> pc_value_out == 21'h000018) else $error("low vector wrong");
    AST_PC_STEP: assert property (wk && !vec |=> pc_value_out == $past(pc_in) + 2'd2)
        else $error("wake resume address wrong");
    AST_IDLE: assert property (!(hi | wake_irq_in | wake_watchdog_in)
        |=> !pc_load_out && init_class_out == 2'd0) else $error("load without event");
    AST_SOFT_ON: assert property (por_event_in && bo1 ##1 bo1 |=> soft_brownout_enable_out)
        else $error("soft brown-out not set");
    AST_SOFT_OFF: assert property (!bo1 && $past(brownout_config_field_in) != 2'b01
        |-> !soft_brownout_enable_out) else $error("soft brown-out outside mode");
endmodule
bind rsi_top rsi_chk #(.PC_W(PC_W)) rsi_chk_i (.clk_in(clk_in), .rst_in(rst_in),
    .por_event_in(por_event_in), .master_clear_pin_class_event_in(master_clear_pin_class_event_in),
    .wake_watchdog_in(wake_watchdog_in), .wake_irq_in(wake_irq_in),
    .wake_irq_high_in(wake_irq_high_in), .global_high_irq_enable_in(global_high_irq_enable_in),
    .global_low_irq_enable_in(global_low_irq_enable_in), .pc_in(pc_in),
    .brownout_config_field_in(brownout_config_field_in), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .init_class_out(init_class_out),
    .soft_brownout_enable_out(soft_brownout_enable_out));

// File: testbench/tb_rsi_top.sv
`timescale 1ns/100ps
module tb_rsi_top;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic [4:0]  ev = 5'h00;
    logic [7:0]  src = 8'h00;
    logic        gie_h = 1'b0;
    logic        gie_l = 1'b0;
    logic [20:0] pc;
    logic [1:0]  bo_cfg = 2'b01;
    logic        osc_r = 1'b1;
    logic        pc_load;
    logic [20:0] pcv;
    logic [1:0]  cls;
    logic        sbo;
    logic        set_en = 1'b0;
    logic [20:0] set_pc = 21'h000000;
    int          bad_count = 0;
    int          check_count = 0;
    logic [7:0]  q;
    logic [7:0]  e [13];
    logic [7:0]  b [13];
    logic [7:0]  rst_tab [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
                                  8'h05, 8'h00, 8'hff, 8'h07, 8'h02, 8'h00};
    always #12.5 clk_in = ~clk_in;
    rsi_top rsi_top_i (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .por_event_in(ev[4]), .master_clear_pin_class_event_in(ev[3]), .wake_watchdog_in(ev[2]),
        .wake_irq_in(ev[1]), .wake_irq_high_in(ev[0]), .irq_source_in(src),
        .global_high_irq_enable_in(gie_h), .global_low_irq_enable_in(gie_l), .pc_in(pc),
        .brownout_config_field_in(bo_cfg), .osc_reset_cond_in(osc_r),
        .osc_wake_cond_in(1'b1), .pc_load_out(pc_load), .pc_value_out(pcv),
        .init_class_out(cls), .soft_brownout_enable_out(sbo));
    rsi_core_model rsi_core_model_i (.clk_in(clk_in), .rst_in(rst_in), .pc_load_in(pc_load),
        .pc_value_in(pcv), .set_en_in(set_en), .set_pc_in(set_pc), .pc_out(pc));
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Request held until waitrequest is sampled low; bounded wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        adr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            final_report();
        end
        q = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic fire(input logic [4:0] x);
        @(posedge clk_in);
        ev <= x;
        @(posedge clk_in);
        ev <= 5'h00;
        @(posedge clk_in);
    endtask
    task automatic sweep(input string nm);
        for (int i = 0; i < 13; i++) begin
            bus(1'b0, 8'(i * 4), 8'h00);
            chk($sformatf("%s%0d", nm, i), e[i], q);
        end
    endtask
    task automatic grab(input logic w);
        for (int i = 0; i < 13; i++) begin
            bus(w, 8'(i * 4), 8'hff);
            b[i] = q;
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        e = rst_tab;
        sweep("rst");
        bus(1'b1, 8'h40, 8'hff);
        bus(1'b0, 8'h40, 8'h00);
        chk("unmapped", 8'h00, q);
        grab(1'b1);
        grab(1'b0);
        chk("unimpl", 8'h00, b[0] & 8'he0 | b[3] & 8'h20 | b[4] & 8'h01 | b[7] & 8'h40);
        chk("nv", 8'h00, b[12]);
        fire(5'h10);
        e[5] = {7'h00, b[5][0]};
        e[6] = 8'h48;
        sweep("por");
        chk("pcv", 21'h0, pcv);
        bus(1'b0, 8'h34, 8'h00);
        chk("sbo", 8'h01, q);
        grab(1'b1);
        grab(1'b0);
        osc_r <= 1'b0;
        fire(5'h08);
        e = rst_tab;
        e[3] = b[3] & 8'hc0;
        e[5] = {7'h00, b[5][0]};
        e[8] = b[8] & 8'hbf;
        sweep("master_clear_pin");
        bus(1'b0, 8'h34, 8'h00);
        chk("sbo_kept", 8'h01, q);
        set_pc <= 21'h012345;
        set_en <= 1'b1;
        gie_h <= 1'b1;
        src <= 8'h05;
        bus(1'b1, 8'h24, 8'h00);
        bus(1'b1, 8'h28, 8'h5a);
        grab(1'b0);
        set_en <= 1'b0;
        fire(5'h03);
        e = b;
        e[0] = 8'h01;
        e[1] = 8'h23;
        e[2] = 8'h45;
        e[3] = b[3] + 8'h01;
        e[4] = 8'h08;
        e[6] = b[6] | 8'h02;
        e[9] = 8'hff;
        sweep("irqh");
        chk("vec_h", 21'h8, pcv);
        bus(1'b0, 8'h38, 8'h00);
        chk("flags", 8'h05, q & 8'h05);
        bus(1'b0, 8'h3c, 8'h00);
        chk("cause_wake", 8'h03, q);
        gie_h <= 1'b0;
        gie_l <= 1'b1;
        fire(5'h02);
        chk("vec_l", 21'h18, pcv);
        bus(1'b0, 8'h08, 8'h00);
        chk("tos_l", 8'h08, q);
        fire(5'h04);
        chk("wdt_pc", 21'h1a, pcv);
        bus(1'b0, 8'h10, 8'h00);
        chk("wdt_pcl", 8'h1a, q);
        gie_l <= 1'b0;
        fire(5'h02);
        chk("nogie_pc", 21'h1c, pcv);
        bus(1'b0, 8'h0c, 8'h00);
        chk("nogie_stk", b[3] + 8'h02, q);
        fire(5'h1b);
        chk("mix_pc", 21'h0, pcv);
        bus(1'b0, 8'h0c, 8'h00);
        chk("mix_stk", 8'h00, q);
        bo_cfg <= 2'b10;
        fire(5'h10);
        chk("sbo_off", 1'b0, sbo);
        bus(1'b0, 8'h34, 8'h00);
        chk("sbo_rd", 8'h00, q);
        final_report();
    end
endmodule
